// File: src/smbcf_pkg.sv
// Package: register map, field positions and timing figures of the bus configuration block
package smbcf_pkg;
  localparam logic [7:0] SBC_ADDR       = 8'hc1;  // serial_bus_clock_config address
  localparam logic [7:0] SBC_PAGE       = 8'h00;  // Register page
  localparam logic [7:0] SBC_RESET      = 8'h00;  // Value after reset
  localparam int         BIT_ENABLE     = 7;      // interface_enable_bit
  localparam int         BIT_INHIBIT    = 6;      // slave_inhibit_bit
  localparam int         BIT_BUSY       = 5;      // transfer_busy_flag
  localparam int         BIT_HOLDEXT    = 4;      // hold_extension_bit
  localparam int         BIT_SCLTO      = 3;      // scl_timeout_enable
  localparam int         BIT_FREETO     = 2;      // free_timeout_enable
  localparam int         BIT_CSEL_HI    = 1;      // clock_source_select msb
  localparam int         BIT_CSEL_LO    = 0;      // clock_source_select lsb
  localparam logic [3:0] FREE_PERIODS   = 4'ha;   // Free after more than this many periods
  localparam logic [3:0] SETUP_NORM_CYC = 4'h1;   // Setup floor, extension off
  localparam logic [3:0] HOLD_NORM_CYC  = 4'h3;   // Hold, extension off
  localparam logic [3:0] SETUP_EXT_CYC  = 4'hb;   // Setup, extension on
  localparam logic [3:0] HOLD_EXT_CYC   = 4'hc;   // Hold, extension on
  localparam int         SCL_TIMEOUT_MS = 25;     // Software sets the timeout timer to this

  typedef enum logic [1:0] {
    SMBCF_SRC_T0,
    SMBCF_SRC_T1,
    SMBCF_SRC_T2H,
    SMBCF_SRC_T2L
  } smbcf_src_t;
endpackage : smbcf_pkg

// File: src/smbcf_mon_if.sv
// Interface: synchronised lines and bus condition events between top and line monitor
`timescale 1ns/1ps
`default_nettype none
interface smbcf_mon_if;
  logic scl;    // Synchronised clock line
  logic sda;    // Synchronised data line
  logic tick;   // Selected overflow pulse
  logic en;     // Interface enabled
  logic fte;    // Free timeout enabled
  logic start;  // START seen, one cycle
  logic stop;   // STOP seen, one cycle
  logic free;   // Free timeout reached, one cycle
  modport top (output scl, sda, tick, en, fte, input start, stop, free);
  modport mon (input scl, sda, tick, en, fte, output start, stop, free);
endinterface : smbcf_mon_if
`default_nettype wire

// File: src/smbcf_mon.sv
// Line monitor: START and STOP detection and bus free timeout
`timescale 1ns/1ps
`default_nettype none
module smbcf_mon
  import smbcf_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst_n,
  smbcf_mon_if.mon    mi
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] free_cnt_r;
  logic [3:0] free_cnt_nxt;
  logic       start_r;
  logic       stop_r;
  logic       free_r;
  wire        both_high = mi.scl & mi.sda;
  wire        sda_fall  = sda_q_r & ~mi.sda;
  wire        sda_rise  = ~sda_q_r & mi.sda;
  wire        free_hit  = mi.fte & both_high & mi.tick & (free_cnt_r == FREE_PERIODS);

  // Count overflow periods with both lines high, stop one past the limit
  assign free_cnt_nxt = (!both_high || !mi.en) ? 4'h0 :
                        (mi.tick && free_cnt_r <= FREE_PERIODS) ? free_cnt_r + 4'h1 :
                        free_cnt_r;

  // Conditions are only recognised while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      free_cnt_r <= 4'h0;
      start_r    <= 1'b0;
      stop_r     <= 1'b0;
      free_r     <= 1'b0;
    end else begin
      scl_q_r    <= mi.scl;
      sda_q_r    <= mi.sda;
      free_cnt_r <= free_cnt_nxt;
      start_r    <= mi.en & mi.scl & scl_q_r & sda_fall;
      stop_r     <= mi.en & mi.scl & scl_q_r & sda_rise;
      free_r     <= mi.en & free_hit;
    end
  end

  assign mi.start = start_r;
  assign mi.stop  = stop_r;
  assign mi.free  = free_r;

  // Free only after eleven high periods in a row
  a_free_late: assert property (@(posedge clk) disable iff (!rst_n)
    free_hit |-> free_cnt_r > 4'h9)
    else $error("free timeout before more than ten periods");
endmodule : smbcf_mon
`default_nettype wire

// File: src/smbcf_top.sv
// Top: configuration register, busy tracking, timer reload and bus timing gates
`timescale 1ns/1ps
`default_nettype none
module smbcf_top
  import smbcf_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_PAGE,
  input  wire logic       SFR_WR,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic       T0_OVF,
  input  wire logic       T1_OVF,
  input  wire logic       T2H_OVF,
  input  wire logic       T2L_OVF,
  input  wire logic       TMR_SPLIT,
  input  wire logic       SLAVE_EVT,
  input  wire logic       MASTER_EVT,
  output logic            IF_ACTIVE,
  output logic            BIT_TICK,
  output logic            SLAVE_IRQ,
  output logic            MASTER_IRQ,
  output logic            ADDR_NACK,
  output logic            TMR_RELOAD_HI,
  output logic            TMR_RELOAD_LO,
  output logic            SCL_MIN_OK,
  output logic            SDA_SETUP_OK,
  output logic            SDA_HOLD_OK
);
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_prev_r;
  logic       sda_prev_r;
  logic       busy_r;
  logic       inh_eff_r;
  logic       tick_r;
  logic       scl_tick_r;
  logic [3:0] scl_fall_cnt_r;
  logic [3:0] sda_chg_cnt_r;
  logic [7:0] rdata_r;
  logic       slave_irq_r;
  logic       master_irq_r;
  logic       rld_hi_r;
  logic       rld_lo_r;
  logic       hold_ok_r;
  logic       setup_ok_r;
  smbcf_mon_if mi ();

  // Field decode
  wire        en       = cfg_r[BIT_ENABLE];
  wire        inh      = cfg_r[BIT_INHIBIT];
  wire        hold_ext = cfg_r[BIT_HOLDEXT];
  wire        scl_toe  = cfg_r[BIT_SCLTO];
  wire        fte      = cfg_r[BIT_FREETO];
  wire smbcf_src_t src = smbcf_src_t'(cfg_r[BIT_CSEL_HI:BIT_CSEL_LO]);
  wire        hit      = (SFR_ADDR == SBC_ADDR) && (SFR_PAGE == SBC_PAGE);
  wire        wr_hit   = SFR_WR & hit;
  wire        scl_s    = scl_sync_r[1];
  wire        sda_s    = sda_sync_r[1];
  wire        scl_edge = scl_s ^ scl_prev_r;
  wire        sda_edge = sda_s ^ sda_prev_r;
  wire [3:0]  hold_min = hold_ext ? HOLD_EXT_CYC : HOLD_NORM_CYC;
  wire [3:0]  setup_min = hold_ext ? SETUP_EXT_CYC : SETUP_NORM_CYC;
  wire [7:0]  cfg_view = {cfg_r[7:6], busy_r, cfg_r[4:0]};

  // Overflow source selection
  wire        tick_sel = (src == SMBCF_SRC_T0)  ? T0_OVF :
                         (src == SMBCF_SRC_T1)  ? T1_OVF :
                         (src == SMBCF_SRC_T2H) ? T2H_OVF : T2L_OVF;

  // Busy bit position of a write is dropped; hardware owns it
  assign cfg_nxt = wr_hit ? {SFR_WDATA[7:6], 1'b0, SFR_WDATA[4:0]} : cfg_r;

  assign mi.scl  = scl_s;
  assign mi.sda  = sda_s;
  assign mi.tick = tick_sel;
  assign mi.en   = en;
  assign mi.fte  = fte;

  smbcf_mon u_mon (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .mi    (mi)
  );

  // Register and pin synchronisers
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_r      <= SBC_RESET;
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      rdata_r    <= SBC_RESET;
    end else begin
      cfg_r      <= cfg_nxt;
      scl_sync_r <= {scl_sync_r[0], SCL_IN};
      sda_sync_r <= {sda_sync_r[0], SDA_IN};
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
      rdata_r    <= hit ? cfg_view : 8'h00;
    end
  end

  // Busy: set wins over nothing, STOP or free clears; disable also clears
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_r    <= 1'b0;
      inh_eff_r <= 1'b0;
    end else begin
      if (!en || mi.stop || mi.free) begin
        busy_r <= 1'b0;
      end else if (mi.start) begin
        busy_r <= 1'b1;
      end
      if (mi.start) begin
        inh_eff_r <= inh;
      end
    end
  end

  // Interrupt gating and timer reload, one cycle registered
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      slave_irq_r  <= 1'b0;
      master_irq_r <= 1'b0;
      rld_hi_r     <= 1'b0;
      rld_lo_r     <= 1'b0;
      tick_r       <= 1'b0;
    end else begin
      slave_irq_r  <= en & SLAVE_EVT & ~inh_eff_r;
      master_irq_r <= en & MASTER_EVT;
      rld_hi_r     <= scl_toe & scl_s;
      rld_lo_r     <= scl_toe & scl_s & ~TMR_SPLIT;
      tick_r       <= en & tick_sel;
    end
  end

  // Timing gates; a counter saturates so long idle periods cannot wrap
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_tick_r     <= 1'b0;
      scl_fall_cnt_r <= 4'h0;
      sda_chg_cnt_r  <= 4'h0;
      hold_ok_r      <= 1'b0;
      setup_ok_r     <= 1'b0;
    end else begin
      if (scl_edge) begin
        scl_tick_r <= 1'b0;
      end else if (tick_sel) begin
        scl_tick_r <= 1'b1;
      end
      if (scl_edge && !scl_s) begin
        scl_fall_cnt_r <= 4'h1;
      end else if (scl_fall_cnt_r != 4'hf) begin
        scl_fall_cnt_r <= scl_fall_cnt_r + 4'h1;
      end
      if (sda_edge) begin
        sda_chg_cnt_r <= 4'h1;
      end else if (sda_chg_cnt_r != 4'hf) begin
        sda_chg_cnt_r <= sda_chg_cnt_r + 4'h1;
      end
      hold_ok_r  <= !scl_s && scl_fall_cnt_r >= hold_min;
      setup_ok_r <= sda_chg_cnt_r >= setup_min;
    end
  end

  assign SFR_RDATA     = rdata_r;
  assign IF_ACTIVE     = cfg_r[BIT_ENABLE];
  assign BIT_TICK      = tick_r;
  assign SLAVE_IRQ     = slave_irq_r;
  assign MASTER_IRQ    = master_irq_r;
  assign ADDR_NACK     = inh_eff_r;
  assign TMR_RELOAD_HI = rld_hi_r;
  assign TMR_RELOAD_LO = rld_lo_r;
  assign SCL_MIN_OK    = scl_tick_r;
  assign SDA_SETUP_OK  = setup_ok_r;
  assign SDA_HOLD_OK   = hold_ok_r;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_busy_set: assert property (en && mi.start && !mi.stop |=> busy_r)
    else $error("busy not set on start");
  a_busy_clear: assert property (mi.stop || mi.free |=> !busy_r)
    else $error("busy not cleared by stop or free");
  a_busy_wr: assert property (wr_hit && !mi.start |=> $stable(busy_r) || !busy_r)
    else $error("busy changed by software write");
  a_reload_hi: assert property (scl_toe && scl_s && !wr_hit |=> TMR_RELOAD_HI)
    else $error("timer not held in reload while clock high");
  a_reload_split: assert property (TMR_SPLIT && $past(TMR_SPLIT) |-> !TMR_RELOAD_LO)
    else $error("low byte reloaded in split mode");
  a_slave_inh: assert property (inh_eff_r && SLAVE_EVT |=> !SLAVE_IRQ)
    else $error("slave interrupt while inhibited");
  a_master_irq: assert property (en && MASTER_EVT && !wr_hit |=> MASTER_IRQ)
    else $error("master interrupt lost");
  a_inh_start: assert property (!mi.start && !inh_eff_r |=> !ADDR_NACK)
    else $error("inhibit took effect before start");
  a_read_view: assert property (hit |=> SFR_RDATA[BIT_BUSY] == $past(busy_r))
    else $error("read data does not show busy");
  a_hold_time: assert property (hold_ok_r |-> $past(scl_fall_cnt_r) >= HOLD_NORM_CYC)
    else $error("hold time shorter than three clocks");
  a_tick_sel: assert property (en && src == SMBCF_SRC_T1 && T1_OVF && !wr_hit |=> BIT_TICK)
    else $error("selected overflow not passed");
  a_scl_min: assert property (scl_edge |=> !SCL_MIN_OK)
    else $error("minimum clock time not restarted");
endmodule : smbcf_top
`default_nettype wire

// File: sim/smbcf_bus_model.sv
// Partner model: another bus device on the shared clock and data lines
`timescale 1ns/1ps
`default_nettype none
module smbcf_bus_model (
  output var logic scl,
  output var logic sda
);
  localparam time HALF = 160ns;  // Half of the 320 ns link clock

  // Pull-ups keep both lines high between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // One half link period, then the clock line moves
  task automatic clk_to(input logic v);
    #HALF scl <= v;  // Non-blocking, so a change on a clock edge lands after it
  endtask : clk_to

  // One half link period, then the data line moves
  task automatic dat_to(input logic v);
    #HALF sda <= v;  // Same edge ordering as the clock line
  endtask : dat_to
endmodule : smbcf_bus_model
`default_nettype wire

// File: sim/tb_top.sv
// Testbench: register access, line conditions, events and timing gates
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smbcf_pkg::*;
  logic       clk, rst_n, wr_en, split, sevt, mevt;
  logic [7:0] addr, page, wdat, rdata;
  logic [3:0] ovf;
  logic       act, tick, sirq, mirq, nack, rl_hi, rl_lo, min_ok, su_ok, ho_ok;
  wire  logic scl_line, sda_line;
  int         errors = 0;
  int         checks = 0;

  smbcf_bus_model bus (.scl(scl_line), .sda(sda_line));
  smbcf_top dut (.REF_CLK(clk), .RESETN(rst_n), .SFR_ADDR(addr), .SFR_PAGE(page),
    .SFR_WR(wr_en), .SFR_WDATA(wdat), .SFR_RDATA(rdata), .SCL_IN(scl_line),
    .SDA_IN(sda_line), .T0_OVF(ovf[0]), .T1_OVF(ovf[1]), .T2H_OVF(ovf[2]),
    .T2L_OVF(ovf[3]), .TMR_SPLIT(split), .SLAVE_EVT(sevt), .MASTER_EVT(mevt),
    .IF_ACTIVE(act), .BIT_TICK(tick), .SLAVE_IRQ(sirq), .MASTER_IRQ(mirq),
    .ADDR_NACK(nack), .TMR_RELOAD_HI(rl_hi), .TMR_RELOAD_LO(rl_lo),
    .SCL_MIN_OK(min_ok), .SDA_SETUP_OK(su_ok), .SDA_HOLD_OK(ho_ok));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] p = SBC_PAGE);
    @(posedge clk) begin addr <= a; page <= p; wdat <= v; wr_en <= 1'b1; end
    @(posedge clk) wr_en <= 1'b0;
  endtask : wr

  // Read data is registered, so hold the address two edges
  task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
    @(posedge clk) begin addr <= a; page <= p; end
    repeat (2) @(posedge clk);
    #1 chk(rdata, e);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) ovf <= 4'h1;
      @(posedge clk) ovf <= 4'h0;
    end
  endtask : ticks

  task automatic evt(input logic s, input logic m, input logic es, input logic em);
    @(posedge clk) begin sevt <= s; mevt <= m; end
    @(posedge clk) begin sevt <= 1'b0; mevt <= 1'b0; end
    #1 chk(sirq, es);
    chk(mirq, em);
  endtask : evt

  task automatic start_cond();
    bus.dat_to(1'b0);
    bus.clk_to(1'b0);
    repeat (8) @(posedge clk);
    #1;
  endtask : start_cond

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    #200us;
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    split = 1'b0;
    sevt  = 1'b0;
    mevt  = 1'b0;
    addr  = 8'h00;
    page  = 8'h00;
    wdat  = 8'h00;
    ovf   = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(SBC_ADDR, SBC_PAGE, SBC_RESET);
    chk(act, 1'b0);
    wr(SBC_ADDR, 8'hff);
    rd(SBC_ADDR, SBC_PAGE, 8'hdf);
    chk(act, 1'b1);
    wr(8'hc2, 8'h00);
    wr(SBC_ADDR, 8'h00, 8'h0f);
    rd(SBC_ADDR, SBC_PAGE, 8'hdf);
    rd(8'hc2, SBC_PAGE, 8'h00);
    rd(SBC_ADDR, 8'h0f, 8'h00);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr(SBC_ADDR, 8'h80 | 8'(s));
      for (int t = 0; t < 4; t++) begin
        @(posedge clk) ovf <= 4'h1 << t;
        @(posedge clk) ovf <= 4'h0;
        #1 chk(tick, 1'(s == t));
      end
    end
    $display("test clock source done");
    wr(SBC_ADDR, 8'h80);
    evt(1'b1, 1'b1, 1'b1, 1'b1);
    wr(SBC_ADDR, 8'hc0);
    evt(1'b1, 1'b0, 1'b1, 1'b0);
    start_cond();
    chk(nack, 1'b1);
    evt(1'b1, 1'b1, 1'b0, 1'b1);
    rd(SBC_ADDR, SBC_PAGE, 8'he0);
    bus.clk_to(1'b1);
    bus.dat_to(1'b1);
    repeat (8) @(posedge clk);
    rd(SBC_ADDR, SBC_PAGE, 8'hc0);
    wr(SBC_ADDR, 8'h00);
    evt(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test events and busy done");
    // Both lines back high without a STOP, then count overflows
    wr(SBC_ADDR, 8'h84);
    start_cond();
    bus.dat_to(1'b1);
    bus.clk_to(1'b1);
    repeat (8) @(posedge clk);
    rd(SBC_ADDR, SBC_PAGE, 8'ha4);
    ticks(10);
    rd(SBC_ADDR, SBC_PAGE, 8'ha4);
    ticks(1);
    rd(SBC_ADDR, SBC_PAGE, 8'h84);
    $display("test free timeout done");
    wr(SBC_ADDR, 8'h88);
    repeat (4) @(posedge clk);
    #1 chk({rl_hi, rl_lo}, 8'h3);
    @(posedge clk) split <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({rl_hi, rl_lo}, 8'h2);
    start_cond();
    chk({rl_hi, rl_lo}, 8'h0);
    // Timeout service routine: disable and re-enable clears the stuck transfer
    wr(SBC_ADDR, 8'h08);
    wr(SBC_ADDR, 8'h88);
    rd(SBC_ADDR, SBC_PAGE, 8'h88);
    @(posedge clk) split <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({rl_hi, rl_lo}, 8'h0);
    $display("test timer reload done");
    for (int e = 0; e < 2; e++) begin
      wr(SBC_ADDR, {3'h4, e[0], 4'h0});
      bus.clk_to(1'b1);
      bus.clk_to(1'b0);
      repeat (8) @(posedge clk);
      #1 chk(ho_ok, !e[0]);
      chk(min_ok, 1'b0);
      bus.dat_to(!sda_line);
      repeat (6) @(posedge clk);
      #1 chk(su_ok, !e[0]);
      ticks(1);
      repeat (20) @(posedge clk);
      #1 chk({min_ok, su_ok, ho_ok}, 8'h7);
    end
    $display("test line timing done");
    // Reset in mid-run returns every bit to zero
    wr(SBC_ADDR, 8'hdf);
    @(posedge clk) rst_n <= 1'b0;
    #1 chk(rdata, 8'h00);
    chk(act, 1'b0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(SBC_ADDR, SBC_PAGE, SBC_RESET);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
